// *** rtl/ppcs_defs.vh ***
// Register map, field layout and timing constants of the port control and status bank
// Functional notes
// - Discovery-limit-disable bit stops the 19 to 29.5 kohm discovery fault window.
// - DC-disconnect-disable bit turns off DC disconnect detection for AC disconnect.
// - Function code 0000 powers down and resets the port; it is the reset value.
// - Codes 0001, 0010, 0011 start discovery one, discovery two, voltage sample.
// - Codes 0100, 0101, 0110 start legacy detection, classification, power ramp-up.
// - Code 0111 starts continuous sampling.
// - Code 1000 ramps power down; 1001 AC low drive; 1010 AC high drive.
// - Code 1011 takes a current sample; 1100 a die temperature sample.
// - Port disable bit set to 1 disables the port; reset value 0 is normal.
// - Conversion start self-clears after starting; abort bit aborts a running conversion.
// - Function done sets on completion under codes other than 0000 and clears on a new function write with no completion in that cycle.
// - Fault cause 000 none, 001 voltage range fault, 010 thermal shutdown fault.
// - Fault cause 011 when overload current lasts longer than 50 ms.
// - Fault cause 100 on load disconnect; codes 101 to 111 never produced.
`ifndef PPCS_DEFS_VH
`define PPCS_DEFS_VH

`define PPCS_ADDR_W 4
`define PPCS_OFS_FUNC 4'h2
`define PPCS_OFS_ENCONV 4'h3
`define PPCS_OFS_STATUS 4'h4
`define PPCS_OFS_IRQ_STAT 4'h8
`define PPCS_OFS_IRQ_EN 4'h9
`define PPCS_OFS_IRQ_CLR 4'hA

`define PPCS_FUNC_LSB 0
`define PPCS_FUNC_MSB 3
`define PPCS_DCDIS_BIT 4
`define PPCS_DISCLIM_BIT 5
`define PPCS_ABORT_BIT 2
`define PPCS_START_BIT 3
`define PPCS_PORTDIS_BIT 4
`define PPCS_FAULT_LSB 0
`define PPCS_FAULT_MSB 2
`define PPCS_CLASS_LSB 3
`define PPCS_CLASS_MSB 5
`define PPCS_DONE_BIT 6
`define PPCS_DISCFAIL_BIT 7

`define PPCS_FN_DISABLE 4'h0
`define PPCS_FN_DISC1 4'h1
`define PPCS_FN_DISC2 4'h2
`define PPCS_FN_VSAMPLE 4'h3
`define PPCS_FN_LEGACY 4'h4
`define PPCS_FN_CLASSIFY 4'h5
`define PPCS_FN_RAMPUP 4'h6
`define PPCS_FN_CSAMPLE 4'h7
`define PPCS_FN_RAMPDN 4'h8
`define PPCS_FN_ACLOW 4'h9
`define PPCS_FN_ACHIGH 4'hA
`define PPCS_FN_ISAMPLE 4'hB
`define PPCS_FN_TSAMPLE 4'hC

`define PPCS_FLT_NONE 3'h0
`define PPCS_FLT_VRANGE 3'h1
`define PPCS_FLT_THERMAL 3'h2
`define PPCS_FLT_OVERLOAD 3'h3
`define PPCS_FLT_DISCONNECT 3'h4
`define PPCS_CLASS_MAX 3'h4

`define PPCS_IRQ_DONE 0
`define PPCS_IRQ_FAULT 1
`define PPCS_IRQ_DISCFAIL 2
`define PPCS_IRQ_W 3

`define PPCS_CLK_HZ 10000000
`define PPCS_OVERLOAD_MS 50

`endif

// *** rtl/ppcs_port_regs.v ***
// Per-port function control, conversion control and result status register bank
`timescale 1ns/100ps
`include "ppcs_defs.vh"
module ppcs_port_regs #(
  parameter OVERLOAD_CYC = (`PPCS_CLK_HZ / 1000) * `PPCS_OVERLOAD_MS
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  output wire irq,
  output wire [12:0] func_sel,
  output wire func_new,
  output wire disc_limit_en,
  output wire dc_disc_en,
  output wire port_disable,
  output wire conv_start,
  output wire conv_abort,
  input wire func_done,
  input wire disc_fail,
  input wire [2:0] port_class,
  input wire vrange_fault,
  input wire thermal_fault,
  input wire overload_raw,
  input wire load_disconnect
);
  localparam CNT_W = 24;
  localparam [CNT_W-1:0] OVL_LIMIT = OVERLOAD_CYC;

  reg [3:0] func_reg;
  reg disc_lim_dis_reg;
  reg dc_dis_reg;
  reg port_dis_reg;
  reg start_reg;
  reg abort_reg;
  reg done_reg;
  reg discfail_reg;
  reg [2:0] class_reg;
  reg [2:0] fault_reg;
  reg [2:0] fault_next;
  reg [CNT_W-1:0] ovl_cnt_reg;
  reg ovl_long_reg;
  reg [`PPCS_IRQ_W-1:0] irq_stat_reg;
  reg [`PPCS_IRQ_W-1:0] irq_en_reg;
  reg [`PPCS_IRQ_W-1:0] irq_set;
  reg done_d_reg;
  reg fault_d_reg;
  reg discfail_d_reg;

  // Status inputs come from outside this clock domain, so each passes two flops
  reg [9:0] sync1_reg;
  reg [9:0] sync2_reg;
  wire [9:0] async_in;
  assign async_in = {load_disconnect, overload_raw, thermal_fault, vrange_fault,
                     port_class, disc_fail, func_done, 1'b0};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 10'h000;
      sync2_reg <= 10'h000;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  wire s_done = sync2_reg[1];
  wire s_discfail = sync2_reg[2];
  wire [2:0] s_class = sync2_reg[5:3];
  wire s_vrange = sync2_reg[6];
  wire s_thermal = sync2_reg[7];
  wire s_overload = sync2_reg[8];
  wire s_disconnect = sync2_reg[9];

  wire wr_func = wr_en && (addr == `PPCS_OFS_FUNC);
  wire wr_enconv = wr_en && (addr == `PPCS_OFS_ENCONV);

  // Function field and port configuration bits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_reg <= `PPCS_FN_DISABLE;
      disc_lim_dis_reg <= 1'b0;
      dc_dis_reg <= 1'b0;
      port_dis_reg <= 1'b0;
    end else begin
      if (wr_func) begin
        func_reg <= wdata[`PPCS_FUNC_MSB:`PPCS_FUNC_LSB];
        disc_lim_dis_reg <= wdata[`PPCS_DISCLIM_BIT];
        dc_dis_reg <= wdata[`PPCS_DCDIS_BIT];
      end
      if (wr_enconv)
        port_dis_reg <= wdata[`PPCS_PORTDIS_BIT];
    end
  end

  // One-hot decode of the active function; spare codes select nothing
  genvar g;
  generate
    for (g = 0; g < 13; g = g + 1) begin : g_fn
      assign func_sel[g] = (func_reg == g) && !port_dis_reg;
    end
  endgenerate
  assign func_new = wr_func;
  assign disc_limit_en = !disc_lim_dis_reg;
  assign dc_disc_en = !dc_dis_reg;
  assign port_disable = port_dis_reg;

  // Start is a one-cycle pulse that clears itself; abort is a held level
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      start_reg <= wr_enconv && wdata[`PPCS_START_BIT];
      if (wr_enconv)
        abort_reg <= wdata[`PPCS_ABORT_BIT];
    end
  end
  assign conv_start = start_reg;
  assign conv_abort = abort_reg;

  // Overload must persist beyond the limit before it is reported
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovl_cnt_reg <= {CNT_W{1'b0}};
      ovl_long_reg <= 1'b0;
    end else if (!s_overload) begin
      ovl_cnt_reg <= {CNT_W{1'b0}};
      ovl_long_reg <= 1'b0;
    end else if (ovl_cnt_reg < OVL_LIMIT) begin
      ovl_cnt_reg <= ovl_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      ovl_long_reg <= 1'b1;
    end
  end

  // Priority among simultaneous faults: thermal, voltage, overload, disconnect
  always @* begin
    fault_next = `PPCS_FLT_NONE;
    if (s_thermal)
      fault_next = `PPCS_FLT_THERMAL;
    else if (s_vrange)
      fault_next = `PPCS_FLT_VRANGE;
    else if (ovl_long_reg)
      fault_next = `PPCS_FLT_OVERLOAD;
    else if (s_disconnect)
      fault_next = `PPCS_FLT_DISCONNECT;
  end

  // Done sticks until a new function write; a completion in that cycle wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      discfail_reg <= 1'b0;
      class_reg <= 3'h0;
      fault_reg <= `PPCS_FLT_NONE;
    end else begin
      if (s_done && func_reg != `PPCS_FN_DISABLE)
        done_reg <= 1'b1;
      else if (wr_func)
        done_reg <= 1'b0;
      discfail_reg <= s_discfail;
      class_reg <= (s_class > `PPCS_CLASS_MAX) ? `PPCS_CLASS_MAX : s_class;
      fault_reg <= fault_next;
    end
  end

  // Rising edges of done, fault and discovery failure feed the sticky status
  always @* begin
    irq_set = {`PPCS_IRQ_W{1'b0}};
    irq_set[`PPCS_IRQ_DONE] = done_reg && !done_d_reg;
    irq_set[`PPCS_IRQ_FAULT] = (fault_reg != `PPCS_FLT_NONE) && !fault_d_reg;
    irq_set[`PPCS_IRQ_DISCFAIL] = discfail_reg && !discfail_d_reg;
  end

  wire [`PPCS_IRQ_W-1:0] irq_clr = (wr_en && addr == `PPCS_OFS_IRQ_CLR) ?
                                   wdata[`PPCS_IRQ_W-1:0] : {`PPCS_IRQ_W{1'b0}};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_d_reg <= 1'b0;
      fault_d_reg <= 1'b0;
      discfail_d_reg <= 1'b0;
      irq_stat_reg <= {`PPCS_IRQ_W{1'b0}};
      irq_en_reg <= {`PPCS_IRQ_W{1'b0}};
    end else begin
      done_d_reg <= done_reg;
      fault_d_reg <= (fault_reg != `PPCS_FLT_NONE);
      discfail_d_reg <= discfail_reg;
      // Set beats clear so a coincident event is never lost
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_en && addr == `PPCS_OFS_IRQ_EN)
        irq_en_reg <= wdata[`PPCS_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_reg & irq_en_reg);

  // Read data one cycle after the strobe; unmapped and write-only offsets read zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `PPCS_OFS_FUNC:
          rdata <= {2'b00, disc_lim_dis_reg, dc_dis_reg, func_reg};
        `PPCS_OFS_ENCONV:
          rdata <= {3'b000, port_dis_reg, 1'b0, abort_reg, 2'b00};
        `PPCS_OFS_STATUS:
          rdata <= {discfail_reg, done_reg, class_reg, fault_reg};
        `PPCS_OFS_IRQ_STAT:
          rdata <= {5'b00000, irq_stat_reg};
        `PPCS_OFS_IRQ_EN:
          rdata <= {5'b00000, irq_en_reg};
        default:
          rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule

// *** sim/ppcs_checker.sv ***
// Pin-level assertions for the port control and status bank
`timescale 1ns/100ps
module ppcs_checker (
  input wire clk,
  input wire rst_n,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata,
  input wire [12:0] func_sel,
  input wire func_new,
  input wire disc_limit_en,
  input wire dc_disc_en,
  input wire port_disable,
  input wire conv_start,
  input wire conv_abort,
  input wire thermal_fault
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire w2 = wr_en && addr == 4'h2;
  wire w3 = wr_en && addr == 4'h3;
  a_limit_follows: assert property (w2 |=> disc_limit_en == !$past(wdata[5]))
    else $error("limit enable wrong");
  a_dc_follows: assert property (w2 |=> dc_disc_en == !$past(wdata[4]))
    else $error("dc disconnect enable wrong");
  a_func_decode: assert property (w2 && wdata[3:0] < 4'hD |=>
    port_disable || func_sel == 13'h1 << $past(wdata[3:0])) else $error("decode wrong");
  a_spare_idle: assert property (w2 && wdata[3:0] > 4'hC |=> func_sel == 13'h0)
    else $error("spare code started");
  a_disable_follows: assert property (w3 |=> port_disable == $past(wdata[4]))
    else $error("port disable wrong");
  // A back-to-back start write legally keeps the pulse high for a second cycle
  a_start_pulse: assert property (w3 && wdata[3] |=> conv_start ##1
    (!conv_start || $past(w3 && wdata[3]))) else $error("start not a pulse");
  a_new_marks_write: assert property (func_new == w2)
    else $error("new function strobe wrong");
  a_abort_follows: assert property (w3 |=> conv_abort == $past(wdata[2]))
    else $error("abort wrong");
  a_thermal_code: assert property (thermal_fault[*4] ##1 (rd_en && addr == 4'h4
    && thermal_fault) |=> rdata[2:0] == 3'h2) else $error("thermal code wrong");
  c_start: cover property (conv_start);
  c_spare: cover property (w2 && wdata[3:0] == 4'hF);
  c_disable: cover property (port_disable);
endmodule
bind ppcs_port_regs ppcs_checker i_chk (.*);

// *** sim/ppcs_port_model.sv ***
// Behavioural model of the analogue port side behind the bank
`timescale 1ns/100ps
module ppcs_port_model (
  input wire clk,
  input wire rst_n,
  input wire [12:0] func_sel,
  input wire func_new,
  input wire [3:0] flt,
  input wire [2:0] cls,
  input wire fail,
  output reg func_done,
  output wire disc_fail,
  output wire [2:0] port_class,
  output wire vrange_fault,
  output wire thermal_fault,
  output wire overload_raw,
  output wire load_disconnect
);
  reg [3:0] cnt_reg;
  // Fixed finish delay; disable and spare codes never finish
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      func_done <= 1'b0;
    end else begin
      cnt_reg <= func_new ? 4'h6 : cnt_reg - (cnt_reg != 4'h0);
      func_done <= cnt_reg == 4'h1 && |func_sel[12:1];
    end
  end
  assign disc_fail = fail;
  assign port_class = cls;
  assign {load_disconnect, overload_raw, thermal_fault, vrange_fault} = flt;
endmodule

// *** sim/ppcs_port_regs_test.sv ***
// Directed register-level test of the port control and status bank
`timescale 1ns/100ps
module ppcs_port_regs_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg [3:0] flt = 4'h0;
  reg [2:0] cls = 3'h0;
  reg fail = 1'b0;
  wire [7:0] rdata;
  wire [12:0] func_sel;
  wire [2:0] port_class;
  wire irq, func_new, disc_limit_en, dc_disc_en, port_disable, conv_start, conv_abort;
  wire func_done, disc_fail, vrange_fault, thermal_fault, overload_raw, load_disconnect;
  integer err_count = 0;
  integer checks_done = 0;
  integer k;
  always #50 clk = ~clk;
  ppcs_port_regs #(.OVERLOAD_CYC(20)) i_dut (.*);
  ppcs_port_model i_model (.*);
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(rdata, e);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #2000000 err_count = err_count + 1;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    chk({disc_limit_en, dc_disc_en, func_sel}, {2'b11, 13'h1});
    rd(4'h3, 8'h00);
    for (k = 0; k < 16; k = k + 1) begin
      wr(4'h2, k[7:0]);
      chk(func_sel, k < 13 ? 13'h1 << k : 13'h0);
      rd(4'h4, 8'h00);
      repeat (10) @(posedge clk);
      rd(4'h4, {1'b0, k > 0 && k < 13, 6'h00});
    end
    wr(4'h2, 8'h06);
    wr(4'h3, 8'h1C);
    chk({conv_start, conv_abort, port_disable, func_sel}, 16'hE000);
    @(posedge clk) #1 chk(conv_start, 1'b0);
    rd(4'h3, 8'h14);
    wr(4'h3, 8'h00);
    chk({conv_abort, port_disable, func_sel}, 16'h0040);
    wr(4'h2, 8'hF0);
    chk({disc_limit_en, dc_disc_en}, 2'b00);
    rd(4'h2, 8'h30);
    wr(4'h2, 8'h00);
    chk({disc_limit_en, dc_disc_en, func_sel}, {2'b11, 13'h1});
    wr(4'h4, 8'hFF);
    @(posedge clk) cls <= 3'h7;
    fail <= 1'b1;
    repeat (4) @(posedge clk);
    rd(4'h4, 8'hA0);
    @(posedge clk) cls <= 3'h3;
    fail <= 1'b0;
    wr(4'hA, 8'h07);
    wr(4'h9, 8'h02);
    chk(irq, 1'b0);
    for (k = 0; k < 4; k = k + 1) begin
      @(posedge clk) flt <= 4'h1 << k;
      repeat (4) @(posedge clk);
      if (k == 2) begin
        rd(4'h4, 8'h18);
        repeat (24) @(posedge clk);
      end
      rd(4'h4, 8'h19 + k[7:0]);
      @(posedge clk) flt <= 4'h0;
      repeat (4) @(posedge clk);
    end
    chk(irq, 1'b1);
    rd(4'h8, 8'h02);
    wr(4'h9, 8'h00);
    chk(irq, 1'b0);
    wr(4'h9, 8'h02);
    chk(irq, 1'b1);
    wr(4'hA, 8'h02);
    chk(irq, 1'b0);
    rd(4'hA, 8'h00);
    rd(4'hF, 8'h00);
    end_of_test;
  end
endmodule
